/* hw/scs_pkg.sv */
// constants and types shared by the system clock select and fail monitor
// assumes a single 25 MHz bus clock; oscillator sources arrive as raw pins
package scs_pkg;

  // ----------------------------------------------------------------------
  // clock sources
  // ----------------------------------------------------------------------
  localparam int SRC_N = 5;
  localparam int SEL_W = 3;
  typedef enum logic [2:0] {
    SCS_SRC_RC     = 3'h0,  // internal precision rc
    SCS_SRC_XTAL   = 3'h1,  // crystal or resonator
    SCS_SRC_EXTRC  = 3'h2,  // external rc network
    SCS_SRC_EXTCLK = 3'h3,  // external clock drive
    SCS_SRC_WDTOSC = 3'h4   // low power watchdog oscillator
  } scs_src_t;

  // switch sequencer states
  typedef enum logic [0:0] {
    SCS_SW_RUN  = 1'b0,
    SCS_SW_GATE = 1'b1
  } scs_sw_state_t;

  // ----------------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL     = 5'h00;
  localparam logic [4:0] ADDR_STATUS   = 5'h04;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h08;
  localparam logic [4:0] ADDR_IRQ_CLR  = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_EN   = 5'h10;

  localparam int CTL_SEL_LSB     = 0;
  localparam int CTL_SYS_DET_BIT = 3;
  localparam int CTL_WDT_DET_BIT = 4;
  localparam int CTL_RC_EN_BIT   = 5;
  localparam int CTL_WDT_EN_BIT  = 6;
  localparam logic [7:0] CTL_RST = 8'h60;

  localparam int IRQ_SYS_BIT = 0;
  localparam int IRQ_WDT_BIT = 1;
  localparam int IRQ_W       = 2;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 40;
  localparam int SYS_FAIL_PERIOD_NS = 1000000;  // 1 kHz floor
  localparam int SYS_FAIL_CYCLES    = SYS_FAIL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WDT_FAIL_CYCLES    = 8004;

endpackage

/* hw/scs_clk_switch.sv */
// system clock multiplexer with input synchronisers, glitch-free unless force_i is set
// assumes sel_i is always a valid source index below N
`timescale 1ns/1ns
`default_nettype none
module scs_clk_switch
  import scs_pkg::*;
#(
  parameter int N  = SRC_N,
  parameter int SW = SEL_W
) (
  input  wire logic          clock_i,   // bus clock
  input  wire logic          rst_i,     // sync reset
  input  wire logic [N-1:0]  src_i,     // raw oscillator pins
  input  wire logic [SW-1:0] sel_i,     // wanted source
  input  wire logic          force_i,   // skip wait on old source
  output logic               clk_o,     // system clock
  output logic [SW-1:0]      active_o,  // source now driving
  output logic               busy_o,    // switch in progress
  output logic [N-1:0]       lvl_o      // synchronised source levels
);

  typedef struct packed {
    logic [N-1:0]  s1;
    logic [N-1:0]  s2;
    logic [SW-1:0] cur;
    scs_sw_state_t state;
    logic          out;
  } scs_sw_regs_t;

  scs_sw_regs_t q, d;

  // ----------------------------------------------------------------------
  // switch sequencer
  // ----------------------------------------------------------------------
  // old source is dropped only while low unless force_i is set, new one joined only while low,
  // so without force_i the output never carries a shortened pulse
  always_comb begin
    d    = q;
    d.s1 = src_i;
    d.s2 = q.s1;
    case (q.state)
      SCS_SW_RUN: begin
        d.out = q.s2[q.cur];
        if (sel_i != q.cur && (force_i || !q.s2[q.cur])) begin
          d.state = SCS_SW_GATE;
          d.out   = 1'b0;
        end
      end
      SCS_SW_GATE: begin
        d.out = 1'b0;
        if (!q.s2[sel_i]) begin
          d.cur   = sel_i;
          d.state = SCS_SW_RUN;
        end
      end
      default: d.state = SCS_SW_RUN;
    endcase
  end

  // state register; out of reset the rc oscillator drives
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= '{s1: '0, s2: '0, cur: SW'(SCS_SRC_RC), state: SCS_SW_RUN, out: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign clk_o    = q.out;
  assign active_o = q.cur;
  assign busy_o   = (q.state == SCS_SW_GATE) || (sel_i != q.cur);
  assign lvl_o    = q.s2;

endmodule
`default_nettype wire

/* hw/scs_edge_watch.sv */
// edge timeout watchdog: flags a missing rising edge on a level
// assumes level_i is already in the clock_i domain
`timescale 1ns/1ns
`default_nettype none
module scs_edge_watch #(
  parameter int LIMIT = 8004,
  parameter int CW    = $clog2(LIMIT + 1)
) (
  input  wire logic clock_i,  // bus clock
  input  wire logic rst_i,    // sync reset
  input  wire logic en_i,     // detector enable
  input  wire logic level_i,  // watched clock level
  output logic      fail_o    // one-cycle failure pulse
);

  typedef struct packed {
    logic          last;
    logic [CW-1:0] cnt;
    logic          tripped;
    logic          fail;
  } scs_ew_regs_t;

  scs_ew_regs_t q, d;

  // ----------------------------------------------------------------------
  // timeout counter
  // ----------------------------------------------------------------------
  // one report per outage; re-armed by an edge or by disabling
  always_comb begin
    d      = q;
    d.last = level_i;
    d.fail = 1'b0;
    if (!en_i) begin
      d.cnt     = '0;
      d.tripped = 1'b0;
    end else if (level_i && !q.last) begin
      d.cnt     = '0;
      d.tripped = 1'b0;
    end else if (q.cnt >= CW'(LIMIT - 1)) begin
      d.fail    = !q.tripped;
      d.tripped = 1'b1;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fail_o = q.fail;

endmodule
`default_nettype wire

/* hw/scs_osc_ctrl.sv */
// oscillator control: source select, failure detection and recovery,
// Avalon-MM register slave and interrupt outputs
// assumes oscillator pins are asynchronous to clock_i and that software
// keeps the detector-enable discipline around source changes
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - five selectable sources: rc, crystal, external rc, external clock, watchdog osc
// - detectors left enabled across a change may report a spurious failure
// - reset enables the internal rc oscillator and selects it
// - selecting another source leaves the rc oscillator running while its own enable bit is set
// - primary clock failure raises a non-maskable event
// - primary clock failure switches the system clock to the watchdog osc
// - automatic switch-over only when the watchdog oscillator is enabled
// - after switch-over the cpu runs slowly and gets the failure vector
// - primary detector trips below about 1 kHz
// - watchdog osc failure raises its own event, no source change
// - after watchdog osc failure primary detection is no longer possible
// - watchdog osc failure after 8004 cycles without a watchdog edge
module scs_osc_ctrl
  import scs_pkg::*;
#(
  parameter int SYS_LIMIT = SYS_FAIL_CYCLES,  // primary timeout cycles
  parameter int WDT_LIMIT = WDT_FAIL_CYCLES   // watchdog timeout cycles
) (
  input  wire logic             clock_i,          // bus clock, 25 MHz
  input  wire logic             rst_i,            // sync reset, active high
  // avalon-mm slave
  input  wire logic [4:0]       address_i,        // byte address
  input  wire logic             read_i,           // read request
  input  wire logic             write_i,          // write request
  input  wire logic [31:0]      writedata_i,      // write data
  input  wire logic [3:0]       byteenable_i,     // byte lanes
  output logic [31:0]           readdata_o,       // read data
  output logic                  waitrequest_o,    // stall
  // oscillators
  input  wire logic [SRC_N-1:0] osc_i,            // raw source clocks
  output logic [SRC_N-1:0]      osc_en_o,         // per-source enables
  output logic                  sysclk_o,         // selected system clock
  // cpu events
  output logic                  nmi_o,            // non-maskable level
  output logic [IRQ_W-1:0]      fail_vec_o,       // failure cause
  output logic                  irq_o             // maskable level
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       ctl;       // control register
    logic [IRQ_W-1:0] irq_stat;  // sticky failure flags
    logic [IRQ_W-1:0] irq_en;    // interrupt enables
    logic             forced;    // recovery override active
    logic             wdt_dead;  // watchdog osc found dead
    logic             ack;       // bus answer cycle
    logic [31:0]      rdata;     // captured read data
    logic [IRQ_W-1:0] vec;       // failure vector
  } scs_regs_t;

  localparam scs_regs_t REGS_RST = '{
    ctl: CTL_RST, irq_stat: '0, irq_en: '0, forced: 1'b0,
    wdt_dead: 1'b0, ack: 1'b0, rdata: '0, vec: '0
  };

  scs_regs_t q, d;

  logic [SEL_W-1:0] sel_sw;
  logic [SEL_W-1:0] sel_eff;
  logic [SEL_W-1:0] active;
  logic             busy;
  logic [SRC_N-1:0] lvl;
  logic             sys_det_en;
  logic             wdt_det_en;
  logic             sys_fail;
  logic             wdt_fail;
  logic             rc_en;
  logic             wdt_en;
  logic [31:0]      status_word;
  logic [31:0]      rd_mux;
  logic             req;
  logic             take;
  logic [IRQ_W-1:0] set_bits;
  logic [IRQ_W-1:0] clr_bits;
  logic [2:0]       wsel;

  // ----------------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------------
  // recovery overrides the software choice until software writes control
  assign sel_sw  = q.ctl[CTL_SEL_LSB +: SEL_W];
  assign sel_eff = q.forced ? SEL_W'(SCS_SRC_WDTOSC) : sel_sw;
  assign rc_en   = q.ctl[CTL_RC_EN_BIT];
  assign wdt_en  = q.ctl[CTL_WDT_EN_BIT];

  scs_clk_switch #(
    .N  (SRC_N),
    .SW (SEL_W)
  ) u_switch (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .src_i    (osc_i),
    .sel_i    (sel_eff),
    .force_i  (q.forced),
    .clk_o    (sysclk_o),
    .active_o (active),
    .busy_o   (busy),
    .lvl_o    (lvl)
  );

  // oscillator enables: the rc osc stays on while it is selected or while its own bit is set
  always_comb begin
    osc_en_o = '0;
    for (int i = 0; i < SRC_N; i++) begin
      osc_en_o[i] = (sel_eff == SEL_W'(i));
    end
    osc_en_o[SCS_SRC_RC]     = osc_en_o[SCS_SRC_RC] | rc_en;
    osc_en_o[SCS_SRC_WDTOSC] = osc_en_o[SCS_SRC_WDTOSC] | wdt_en;
  end

  // ----------------------------------------------------------------------
  // failure detectors
  // ----------------------------------------------------------------------
  // no gating on busy: a detector left on through a change may trip,
  // which is the documented hazard of skipping the disable step
  assign sys_det_en = q.ctl[CTL_SYS_DET_BIT]
                    && !q.wdt_dead
                    && (active != SEL_W'(SCS_SRC_WDTOSC));
  assign wdt_det_en = q.ctl[CTL_WDT_DET_BIT] && wdt_en;

  // primary monitor: no rising edge within one 1 kHz period
  scs_edge_watch #(
    .LIMIT (SYS_LIMIT)
  ) u_sys_watch (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .en_i    (sys_det_en),
    .level_i (sysclk_o),
    .fail_o  (sys_fail)
  );

  // watchdog osc monitor: counts cycles while waiting for its edge
  scs_edge_watch #(
    .LIMIT (WDT_LIMIT)
  ) u_wdt_watch (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .en_i    (wdt_det_en),
    .level_i (lvl[SCS_SRC_WDTOSC]),
    .fail_o  (wdt_fail)
  );

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // one wait cycle on every access; the write lands and read data is
  // presented at the edge where waitrequest is low
  assign req  = read_i || write_i;
  assign take = req && q.ack;
  assign waitrequest_o = req && !q.ack;

  assign status_word = {24'h000000, busy, q.wdt_dead, q.forced, sysclk_o, 1'b0, active};

  // read multiplexer; unmapped and write-only offsets read zero
  always_comb begin
    if (address_i == ADDR_CTRL) begin
      rd_mux = {24'h000000, q.ctl};
    end else if (address_i == ADDR_STATUS) begin
      rd_mux = status_word;
    end else if (address_i == ADDR_IRQ_STAT) begin
      rd_mux = {30'h00000000, q.irq_stat};
    end else if (address_i == ADDR_IRQ_EN) begin
      rd_mux = {30'h00000000, q.irq_en};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------------
  always_comb begin
    set_bits = '0;
    set_bits[IRQ_SYS_BIT] = sys_fail;
    set_bits[IRQ_WDT_BIT] = wdt_fail;
    clr_bits = '0;
    if (take && write_i && address_i == ADDR_IRQ_CLR && byteenable_i[0]) begin
      clr_bits = writedata_i[IRQ_W-1:0];
    end
  end

  // a reserved select code keeps the current choice
  assign wsel = (writedata_i[CTL_SEL_LSB +: SEL_W] < 3'(SRC_N))
              ? writedata_i[CTL_SEL_LSB +: SEL_W] : sel_sw;

  // ----------------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------------
  always_comb begin
    d     = q;
    d.ack = req && !q.ack;
    if (req && !q.ack) begin
      d.rdata = rd_mux;
    end
    // software writes
    if (take && write_i && byteenable_i[0]) begin
      if (address_i == ADDR_CTRL) begin
        d.ctl = writedata_i[7:0];
        d.ctl[CTL_SEL_LSB +: SEL_W] = wsel;
        d.ctl[7] = 1'b0;
        d.forced = 1'b0;  // software has chosen a source again
      end else if (address_i == ADDR_IRQ_EN) begin
        d.irq_en = writedata_i[IRQ_W-1:0];
      end
    end
    // sticky flags: a set in the clearing cycle survives
    d.irq_stat = (q.irq_stat & ~clr_bits) | set_bits;
    // automatic recovery needs a running watchdog oscillator
    if (sys_fail && wdt_en) begin
      d.forced = 1'b1;
    end
    // watchdog death ends primary detection until reset
    if (wdt_fail) begin
      d.wdt_dead = 1'b1;
    end
    // vector names the newest cause; the cpu keeps running on the slow clock
    if (sys_fail) begin
      d.vec = IRQ_W'(1 << IRQ_SYS_BIT);
    end else if (wdt_fail) begin
      d.vec = IRQ_W'(1 << IRQ_WDT_BIT);
    end else if (d.irq_stat == '0) begin
      d.vec = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // nmi ignores the enables, irq honours them
  assign readdata_o = q.rdata;
  assign nmi_o      = |q.irq_stat;
  assign irq_o      = |(q.irq_stat & q.irq_en);
  assign fail_vec_o = q.vec;

endmodule
`default_nettype wire

/* sim/scs_osc_ctrl_sva.sv */
// port checker for the oscillator control block
// assumes it is bound to scs_osc_ctrl and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module scs_osc_ctrl_sva
  import scs_pkg::*;
(
  input wire logic             clock_i,        // bus clock
  input wire logic             rst_i,          // sync reset
  input wire logic [4:0]       address_i,      // byte address
  input wire logic             read_i,         // read request
  input wire logic             write_i,        // write request
  input wire logic [31:0]      readdata_o,     // read data
  input wire logic             waitrequest_o,  // stall
  input wire logic [SRC_N-1:0] osc_en_o,       // source enables
  input wire logic             sysclk_o,       // system clock
  input wire logic             nmi_o,          // failure level
  input wire logic [IRQ_W-1:0] fail_vec_o,     // failure cause
  input wire logic             irq_o           // maskable level
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // bus answers after exactly one wait cycle
  a_wait_one: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("waitrequest held past one cycle");
  a_wait_cause: assert property (waitrequest_o |-> read_i || write_i)
    else $error("waitrequest without a request");
  // reset must leave rc and watchdog osc on, rc selected
  a_rc_default: assert property (disable iff (1'b0) rst_i |=> osc_en_o == 5'h11)
    else $error("reset enables wrong");
  // only a control write may drop the rc osc; a recovery switch-over while its own bit is clear would also trip this check
  a_rc_kept: assert property ($fell(osc_en_o[0]) |->
    $past(write_i) && !$past(waitrequest_o) && $past(address_i) == ADDR_CTRL)
    else $error("rc osc dropped without write");
  a_irq_flag: assert property (irq_o |-> nmi_o)
    else $error("irq without failure flag");
  // failure flags are sticky until cleared by software
  a_nmi_sticky: assert property ($fell(nmi_o) |->
    $past(write_i) && !$past(waitrequest_o) && $past(address_i) == ADDR_IRQ_CLR)
    else $error("failure event lost");
  a_vec_follows: assert property ($rose(nmi_o) |-> ##[0:2] fail_vec_o != 2'h0)
    else $error("no failure cause");
  a_clr_reads_zero: assert property (read_i && !waitrequest_o && address_i == ADDR_IRQ_CLR
    |-> readdata_o == 32'h0)
    else $error("clear register read not zero");
  // a runt of one cycle would mean a glitchy switch
  a_clk_no_runt: assert property ($rose(sysclk_o) |=> sysclk_o)
    else $error("runt pulse on system clock");

  c_nmi_irq: cover property (nmi_o && irq_o);
  c_wdt_fail: cover property ($rose(fail_vec_o[1]));
  c_read_done: cover property (read_i && !waitrequest_o);
endmodule

bind scs_osc_ctrl scs_osc_ctrl_sva u_scs_osc_ctrl_sva (
  .clock_i, .rst_i, .address_i, .read_i, .write_i, .readdata_o, .waitrequest_o,
  .osc_en_o, .sysclk_o, .nmi_o, .fail_vec_o, .irq_o);
`default_nettype wire

/* sim/scs_osc_model.sv */
// model of the five oscillator sources feeding the block
// assumes the bench commands stops; a stopped source sits low
`timescale 1ns/1ns
`default_nettype none
module scs_osc_model
  import scs_pkg::*;
(
  input  wire logic [SRC_N-1:0] en_i,    // enables from the block
  input  wire logic [SRC_N-1:0] stop_i,  // commanded failures
  output logic [SRC_N-1:0]      osc_o    // raw source clocks
);
  for (genvar k = 0; k < SRC_N; k++) begin : g_src
    logic ph;
    logic gate;
    initial ph = 1'b0;
    initial gate = 1'b0;
    always #(120 + 40 * k) ph = ~ph;
    // gate only while low, so a start or stop never cuts a pulse short
    always @(negedge ph) gate = en_i[k] & ~stop_i[k];
    assign osc_o[k] = ph & gate;
  end
endmodule
`default_nettype wire

/* sim/test_system_clock_select_and_fail_monitor.sv */
// bench for the oscillator control block: select, failures, recovery
// assumes the oscillator model drives the raw source pins
`timescale 1ns/1ns
`default_nettype none
module test_system_clock_select_and_fail_monitor;
  import scs_pkg::*;
  localparam int SYS_L = 50;  // shortened primary timeout
  localparam int WDT_L = 40;  // shortened watchdog timeout
  logic             clock_i, rst_i, read_i, write_i;
  logic [4:0]       address_i;
  logic [31:0]      writedata_i, readdata_o, rd;
  logic             waitrequest_o, sysclk_o, nmi_o, irq_o;
  logic [SRC_N-1:0] osc_i, osc_en_o, stop;
  logic [IRQ_W-1:0] fail_vec_o;
  int               num_errors, check_count, n;

  scs_osc_ctrl #(.SYS_LIMIT(SYS_L), .WDT_LIMIT(WDT_L)) u_scs_osc_ctrl (
    .clock_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i,
    .byteenable_i(4'hF), .readdata_o, .waitrequest_o, .osc_i, .osc_en_o,
    .sysclk_o, .nmi_o, .fail_vec_o, .irq_o);
  scs_osc_model u_scs_osc_model (.en_i(osc_en_o), .stop_i(stop), .osc_o(osc_i));

  always #20 clock_i = ~clock_i;

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon access; an idle edge after release keeps drives apart
  // waits for the answer however long it takes; only the hang guard ends it
  task automatic bus(logic wr, logic [4:0] a, logic [31:0] d, output logic [31:0] q);
    address_i <= a;
    writedata_i <= d;
    read_i <= !wr;
    write_i <= wr;
    do begin
      @(posedge clock_i);
    end while (waitrequest_o !== 1'b0);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wr(logic [4:0] a, logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask

  task automatic rdr(logic [4:0] a);
    bus(1'b0, a, 32'h0, rd);
  endtask

  task automatic wait_src(logic [2:0] c);
    int k;
    k = 0;
    do begin
      rdr(ADDR_STATUS);
      k++;
    end while ((rd[2:0] !== c || rd[7] !== 1'b0) && k < 60);
  endtask

  // edges since the watched pin last rose, as the detector times from that edge
  task automatic wait_nmi(int src);
    logic prev;
    prev = 1'b1;
    n = 0;
    while (nmi_o !== 1'b1 && n < 300) begin
      @(posedge clock_i);
      n++;
      if (osc_i[src] === 1'b1 && prev === 1'b0) n = 0;
      prev = osc_i[src];
    end
  endtask

  task automatic t_reset;
    rdr(ADDR_CTRL);
    check("ctrl", 32'h60, rd);
    check("osc_en", 5'h11, osc_en_o);
    wr(5'h14, 8'hFF);
    rdr(5'h14);
    check("unmapped", 0, rd);
    rdr(ADDR_IRQ_CLR);
    check("clr_reads", 0, rd);
    rdr(ADDR_CTRL);
    check("ctrl_kept", 32'h60, rd);
    $display("t_reset done");
  endtask

  task automatic t_select;
    for (int c = 1; c <= 5; c++) begin
      wr(ADDR_CTRL, 8'h60 | 8'(c % 5));
      wait_src(3'(c % 5));
      check("active", 32'(c % 5), rd & 32'h87);
      check("rc_on", 1, osc_en_o[0]);
    end
    wr(ADDR_CTRL, 8'h65);
    rdr(ADDR_CTRL);
    check("bad_sel", 32'h60, rd);
    wr(ADDR_CTRL, 8'h41);
    wait_src(3'h1);
    check("rc_off", 0, osc_en_o[0]);
    $display("t_select done");
  endtask

  task automatic t_primary;
    wr(ADDR_CTRL, 8'h61);
    wait_src(3'h1);
    wr(ADDR_CTRL, 8'h69);
    wr(ADDR_IRQ_EN, 8'h01);
    stop <= 5'h02;
    wait_nmi(1);
    check("sys_time", 1, n >= SYS_L && n <= SYS_L + 30);
    check("vec", 1, fail_vec_o);
    wait_src(3'h4);
    check("forced", 32'h24, rd & 32'hA7);
    check("irq", 1, irq_o);
    wr(ADDR_IRQ_CLR, 8'h01);
    check("nmi_clr", 0, nmi_o);
    stop <= 5'h00;
    wr(ADDR_CTRL, 8'h60);
    wait_src(3'h0);
    $display("t_primary done");
  endtask

  task automatic t_nowdt;
    wr(ADDR_CTRL, 8'h21);
    wait_src(3'h1);
    wr(ADDR_CTRL, 8'h29);
    stop <= 5'h02;
    wait_nmi(1);
    check("irq", 1, irq_o);
    wr(ADDR_IRQ_EN, 8'h00);
    check("masked", 0, irq_o);
    check("nmi_kept", 1, nmi_o);
    rdr(ADDR_STATUS);
    check("no_switch", 1, rd[2:0]);
    wr(ADDR_CTRL, 8'h61);
    wr(ADDR_IRQ_CLR, 8'h01);
    stop <= 5'h00;
    wr(ADDR_CTRL, 8'h60);
    wait_src(3'h0);
    $display("t_nowdt done");
  endtask

  task automatic t_wdt;
    wr(ADDR_IRQ_EN, 8'h02);
    wr(ADDR_CTRL, 8'h70);
    stop <= 5'h10;
    wait_nmi(4);
    check("wdt_time", 1, n >= WDT_L && n <= WDT_L + 30);
    check("vec", 2, fail_vec_o);
    check("irq", 1, irq_o);
    rdr(ADDR_STATUS);
    check("dead_src", 32'h40, rd & 32'h47);
    wr(ADDR_IRQ_CLR, 8'h03);
    wr(ADDR_CTRL, 8'h68);
    stop <= 5'h11;
    repeat (150) @(posedge clock_i);
    rdr(ADDR_IRQ_STAT);
    check("no_sys", 0, rd[0]);
    stop <= 5'h00;
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rdr(ADDR_STATUS);
    check("revived", 0, rd[6]);
    $display("t_wdt done");
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = 5'h00;
    writedata_i = 32'h0;
    stop = 5'h00;
    num_errors = 0;
    check_count = 0;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_select();
    t_primary();
    t_nowdt();
    t_wdt();
    close_out();
  end

  // hang guard, well past the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clock_i);
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
